// ### core/tpc_pkg.sv
`default_nettype none
package tpc_pkg;
  // ****************************************
  // Bus geometry
  // ****************************************
  localparam int IDX_W = 8;
  localparam int WB_DW = 32;
  localparam int PIN_N = 4;
  // ****************************************
  // Pin slots in the synchroniser
  // ****************************************
  localparam int PIN_SHARED_TIMER_CLOCK_PIN = 0;
  localparam int PIN_THIRD_TIMER_CLOCK_PIN = 1;
  localparam int PIN_CAPTURE_ONE_PIN = 2;
  localparam int PIN_CAPTURE_TWO_PIN = 3;
  // ****************************************
  // Instruction clock divider
  // ****************************************
  localparam logic [1:0] INSTR_DIV_LAST = 2'h3;
  // ****************************************
  // Register indices, byte address is four times the index
  // ****************************************
  localparam logic [7:0] BANK1_BASE = 8'h20;
  localparam logic [7:0] BANK2_BASE = 8'h40;
  localparam logic [7:0] BANK3_BASE = 8'h60;
  localparam logic [7:0] OFS_CPU_STATUS = 8'h06;
  localparam logic [7:0] OFS_CORE_INT = 8'h07;
  localparam logic [7:0] OFS_T1_COUNT = 8'h10;
  localparam logic [7:0] OFS_T2_COUNT = 8'h11;
  localparam logic [7:0] OFS_PIR = 8'h16;
  localparam logic [7:0] OFS_PIE = 8'h17;
  localparam logic [7:0] OFS_TCFG = 8'h16;
  localparam logic [7:0] OFS_TRUN = 8'h17;
  localparam logic [7:0] IDX_CPU_STATUS = OFS_CPU_STATUS;
  localparam logic [7:0] IDX_CORE_INT = OFS_CORE_INT;
  localparam logic [7:0] IDX_PIR = BANK1_BASE + OFS_PIR;
  localparam logic [7:0] IDX_PIE = BANK1_BASE + OFS_PIE;
  localparam logic [7:0] IDX_T1_COUNT = BANK2_BASE + OFS_T1_COUNT;
  localparam logic [7:0] IDX_T2_COUNT = BANK2_BASE + OFS_T2_COUNT;
  localparam logic [7:0] IDX_T1_PERIOD = 8'h52;
  localparam logic [7:0] IDX_T2_PERIOD = 8'h53;
  localparam logic [7:0] IDX_T3_LO = 8'h54;
  localparam logic [7:0] IDX_T3_HI = 8'h55;
  localparam logic [7:0] IDX_P3_LO = 8'h56;
  localparam logic [7:0] IDX_P3_HI = 8'h57;
  localparam logic [7:0] IDX_C2_LO = 8'h58;
  localparam logic [7:0] IDX_C2_HI = 8'h59;
  localparam logic [7:0] IDX_TCFG = BANK3_BASE + OFS_TCFG;
  localparam logic [7:0] IDX_TRUN = BANK3_BASE + OFS_TRUN;
  // ****************************************
  // Field positions
  // ****************************************
  localparam int B_GLOBAL_IRQ_DISABLE = 4;
  localparam int B_PERIPHERAL_IRQ_ENABLE = 3;
  localparam int B_PEIF = 7;
  localparam int B_T1CS = 0;
  localparam int B_T2CS = 1;
  localparam int B_T3CS = 2;
  localparam int B_CASCADE = 3;
  localparam int B_C1ED = 4;
  localparam int B_C2ED = 6;
  localparam int B_T1ON = 0;
  localparam int B_T2ON = 1;
  localparam int B_T3ON = 2;
  localparam int B_DUALCAP = 3;
  localparam int B_C1OVF = 6;
  localparam int B_C2OVF = 7;
  localparam int B_CAPTURE_ONE_IRQ_FLAG = 2;
  localparam int B_CAPTURE_TWO_IRQ_FLAG = 3;
  localparam int B_T1IF = 4;
  localparam int B_T2IF = 5;
  localparam int B_T3IF = 6;
  // ****************************************
  // Reset values
  // ****************************************
  localparam logic [7:0] RST_PIR = 8'h02;
  localparam logic [7:0] RST_ZERO8 = 8'h00;
  localparam logic [7:0] RST_PERIOD8 = 8'hFF;
  localparam logic [15:0] RST_PERIOD16 = 16'hFFFF;
  localparam logic [7:0] CPU_STATUS_FIXED = 8'h2C;
  // ****************************************
  // Capture event selection
  // ****************************************
  typedef enum logic [1:0] {
    TPC_EV_FALL = 2'h0,
    TPC_EV_RISE = 2'h1,
    TPC_EV_RISE4 = 2'h2,
    TPC_EV_RISE16 = 2'h3
  } tpc_edge_e;
  localparam logic [3:0] PRE4_LAST = 4'h3;
  localparam logic [3:0] PRE16_LAST = 4'hF;
endpackage : tpc_pkg
`default_nettype wire

// ### core/tpc_pin_sync.sv
`default_nettype none
module tpc_pin_sync
  import tpc_pkg::*;
(
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst_n,
  // Raw pins
  input wire logic [PIN_N-1:0] pinIn,
  // Clean edges
  output logic [PIN_N-1:0] pinFall,
  output logic [PIN_N-1:0] pinRise
);
  logic [PIN_N-1:0] stage1;
  logic [PIN_N-1:0] stage2;
  logic [PIN_N-1:0] stage3;
  logic [PIN_N-1:0] level;
  logic [PIN_N-1:0] agree;

  assign agree = ~(stage2 ^ stage3);

  // ****************************************
  // Three stage chain, level taken when stages two and three agree
  // ****************************************
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      stage1 <= '0;
      stage2 <= '0;
      stage3 <= '0;
      level <= '0;
      pinFall <= '0;
      pinRise <= '0;
    end else begin
      stage1 <= pinIn;
      stage2 <= stage1;
      stage3 <= stage2;
      level <= (agree & stage3) | (~agree & level);
      pinFall <= agree & level & ~stage3;
      pinRise <= agree & ~level & stage3;
    end
  end
endmodule : tpc_pin_sync
`default_nettype wire

// ### core/tpc_timer_unit.sv
// Implementation choice: the Wishbone interface to the registers.
`default_nettype none
module tpc_timer_unit
  import tpc_pkg::*;
(
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst_n,
  // Wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [31:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [WB_DW-1:0] wb_dat_i,
  output logic [WB_DW-1:0] wb_dat_o,
  output logic wb_ack_o,
  // Timer and capture pins
  input wire logic sharedTimerClockPin,
  input wire logic thirdTimerClockPin,
  input wire logic captureOnePin,
  input wire logic captureTwoPin,
  // Interrupt request to the core
  output logic periphIrq
);
  // ****************************************
  // State
  // ****************************************
  logic [1:0] instrDiv;
  logic instrTick;
  logic [PIN_N-1:0] pinFall;
  logic [PIN_N-1:0] pinRise;
  logic [7:0] timerCfg;
  logic [5:0] timerRun;
  logic [1:0] capOvf;
  logic [7:0] peripheral_irq_flags;
  logic [7:0] peripheral_irq_enables;
  logic peripheral_irq_enable;
  logic global_irq_disable;
  logic [7:0] cnt1;
  logic [7:0] cnt2;
  logic [7:0] per1;
  logic [7:0] per2;
  logic [15:0] cnt3;
  logic [15:0] per3;
  logic [15:0] capture_two_pin;
  logic [3:0] pre [2];
  logic [1:0] capFull;
  logic [1:0] ovfMaster;
  logic [1:0] rdLo;
  logic [1:0] rdHi;

  // ****************************************
  // Bus decode
  // ****************************************
  logic busReq;
  logic busWr;
  logic busRd;
  logic [IDX_W-1:0] idx;
  logic [7:0] wd;
  assign busReq = wb_cyc_i & wb_stb_i;
  assign busWr = busReq & wb_ack_o & wb_we_i & wb_sel_i[0];
  assign busRd = busReq & wb_ack_o & ~wb_we_i;
  assign idx = wb_adr_i[IDX_W+1:2];
  assign wd = wb_dat_i[7:0];

  function automatic logic wrAt(input logic [7:0] a);
    return busWr && (idx == a);
  endfunction : wrAt

  function automatic logic rdAt(input logic [7:0] a);
    return busRd && (idx == a);
  endfunction : rdAt

  function automatic logic timerTick(input logic ext, input logic fall, input logic tick);
    return ext ? fall : tick;
  endfunction : timerTick

  // ****************************************
  // Instruction clock, oscillator over four
  // ****************************************
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      instrDiv <= '0;
      instrTick <= 1'b0;
    end else begin
      instrDiv <= instrDiv + 2'h1;
      instrTick <= (instrDiv == INSTR_DIV_LAST);
    end
  end

  tpc_pin_sync u_sync (
    .ref_clk(ref_clk),
    .rst_n(rst_n),
    .pinIn({captureTwoPin, captureOnePin, thirdTimerClockPin, sharedTimerClockPin}),
    .pinFall(pinFall),
    .pinRise(pinRise)
  );

  // ****************************************
  // Timer ticks and wrap events
  // ****************************************
  logic dualCap;
  logic tick1;
  logic tick2;
  logic tick3;
  logic wrap1;
  logic wrap2;
  logic wrap3;
  assign dualCap = timerRun[B_DUALCAP];
  assign tick1 = timerRun[B_T1ON] & timerTick(timerCfg[B_T1CS], pinFall[PIN_SHARED_TIMER_CLOCK_PIN], instrTick);
  assign tick2 = timerRun[B_T2ON] & timerTick(timerCfg[B_T2CS], pinFall[PIN_SHARED_TIMER_CLOCK_PIN], instrTick);
  assign tick3 = timerRun[B_T3ON] & timerTick(timerCfg[B_T3CS], pinFall[PIN_THIRD_TIMER_CLOCK_PIN], instrTick);
  assign wrap1 = tick1 & (cnt1 == per1);
  assign wrap2 = tick2 & (cnt2 == per2);
  assign wrap3 = tick3 & (dualCap ? (cnt3 == 16'hFFFF) : (cnt3 == per3));

  // ****************************************
  // Eight bit timers
  // ****************************************
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt1 <= RST_ZERO8;
      cnt2 <= RST_ZERO8;
    end else begin
      if (wrAt(IDX_T1_COUNT)) cnt1 <= wd;
      else if (wrap1) cnt1 <= '0;
      else if (tick1) cnt1 <= cnt1 + 8'h01;
      if (wrAt(IDX_T2_COUNT)) cnt2 <= wd;
      else if (wrap2) cnt2 <= '0;
      else if (tick2) cnt2 <= cnt2 + 8'h01;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      per1 <= RST_PERIOD8;
      per2 <= RST_PERIOD8;
    end else begin
      if (wrAt(IDX_T1_PERIOD)) per1 <= wd;
      if (wrAt(IDX_T2_PERIOD)) per2 <= wd;
    end
  end

  // ****************************************
  // Capture events and prescalers
  // ****************************************
  logic [1:0] capEvt;
  logic [1:0] capDone;
  logic [1:0] capTake;
  logic [1:0] capLost;
  always_comb begin
    for (int c = 0; c < 2; c++) begin
      case (tpc_edge_e'(timerCfg[(c == 0 ? B_C1ED : B_C2ED) +: 2]))
        TPC_EV_FALL: capEvt[c] = pinFall[PIN_CAPTURE_ONE_PIN + c];
        TPC_EV_RISE: capEvt[c] = pinRise[PIN_CAPTURE_ONE_PIN + c];
        TPC_EV_RISE4: capEvt[c] = pinRise[PIN_CAPTURE_ONE_PIN + c] & (pre[c][1:0] == PRE4_LAST[1:0]);
        TPC_EV_RISE16: capEvt[c] = pinRise[PIN_CAPTURE_ONE_PIN + c] & (pre[c] == PRE16_LAST);
        default: capEvt[c] = 1'b0;
      endcase
    end
    capEvt[0] = capEvt[0] & dualCap;
  end

  // Both bytes read completes the unload
  assign capDone[0] = (rdLo[0] | rdAt(IDX_P3_LO)) & (rdHi[0] | rdAt(IDX_P3_HI)) & capFull[0];
  assign capDone[1] = (rdLo[1] | rdAt(IDX_C2_LO)) & (rdHi[1] | rdAt(IDX_C2_HI)) & capFull[1];
  assign capTake = capEvt & ~(capFull & ~capDone);
  assign capLost = capEvt & capFull & ~capDone;

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      pre[0] <= '0;
      pre[1] <= '0;
    end else begin
      for (int c = 0; c < 2; c++) begin
        if (pinRise[PIN_CAPTURE_ONE_PIN + c]) pre[c] <= pre[c] + 4'h1;
      end
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      capFull <= '0;
      ovfMaster <= '0;
      capOvf <= '0;
      rdLo <= '0;
      rdHi <= '0;
    end else begin
      for (int c = 0; c < 2; c++) begin
        if (capDone[c]) begin
          capOvf[c] <= ovfMaster[c] | capLost[c];
          ovfMaster[c] <= 1'b0;
          rdLo[c] <= 1'b0;
          rdHi[c] <= 1'b0;
        end else if (capLost[c]) begin
          ovfMaster[c] <= 1'b1;
        end
        if (capTake[c]) capFull[c] <= 1'b1;
        else if (capDone[c]) capFull[c] <= 1'b0;
      end
      if (capFull[0] && !capDone[0]) begin
        if (rdAt(IDX_P3_LO)) rdLo[0] <= 1'b1;
        if (rdAt(IDX_P3_HI)) rdHi[0] <= 1'b1;
      end
      if (capFull[1] && !capDone[1]) begin
        if (rdAt(IDX_C2_LO)) rdLo[1] <= 1'b1;
        if (rdAt(IDX_C2_HI)) rdHi[1] <= 1'b1;
      end
    end
  end

  // ****************************************
  // Sixteen bit timer, period and capture registers
  // ****************************************
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt3 <= '0;
    end else begin
      if (wrAt(IDX_T3_LO)) cnt3[7:0] <= wd;
      else if (wrAt(IDX_T3_HI)) cnt3[15:8] <= wd;
      else if (wrap3) cnt3 <= '0;
      else if (tick3) cnt3 <= cnt3 + 16'h0001;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      per3 <= RST_PERIOD16;
      capture_two_pin <= '0;
    end else begin
      if (capTake[0]) per3 <= cnt3;
      else if (wrAt(IDX_P3_LO)) per3[7:0] <= wd;
      else if (wrAt(IDX_P3_HI)) per3[15:8] <= wd;
      if (capTake[1]) capture_two_pin <= cnt3;
    end
  end

  // ****************************************
  // Control registers
  // ****************************************
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      timerCfg <= RST_ZERO8;
      timerRun <= '0;
      peripheral_irq_enables <= RST_ZERO8;
      peripheral_irq_enable <= 1'b0;
      global_irq_disable <= 1'b1;
    end else begin
      if (wrAt(IDX_TCFG)) timerCfg <= wd;
      if (wrAt(IDX_TRUN)) timerRun <= wd[5:0];
      if (wrAt(IDX_PIE)) peripheral_irq_enables <= wd;
      if (wrAt(IDX_CORE_INT)) peripheral_irq_enable <= wd[B_PERIPHERAL_IRQ_ENABLE];
      if (wrAt(IDX_CPU_STATUS)) global_irq_disable <= wd[B_GLOBAL_IRQ_DISABLE];
    end
  end

  // ****************************************
  // Flags, hardware set wins over software write
  // ****************************************
  logic [7:0] hwSet;
  assign hwSet = ({7'h00, 1'b0} | ({1'b0, wrap3, wrap2, wrap1, capTake, 2'h0}));
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      peripheral_irq_flags <= RST_PIR;
    end else begin
      peripheral_irq_flags <= (wrAt(IDX_PIR) ? wd : peripheral_irq_flags) | hwSet;
    end
  end

  // ****************************************
  // Interrupt request
  // ****************************************
  logic pendAny;
  assign pendAny = |(peripheral_irq_flags & peripheral_irq_enables);
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) periphIrq <= 1'b0;
    else periphIrq <= pendAny & peripheral_irq_enable & ~global_irq_disable;
  end

  // ****************************************
  // Read mux and acknowledge
  // ****************************************
  function automatic logic [7:0] regRead(input logic [7:0] a);
    case (a)
      IDX_CPU_STATUS: regRead = CPU_STATUS_FIXED | {3'h0, global_irq_disable, 4'h0};
      IDX_CORE_INT: regRead = {pendAny, 3'h0, peripheral_irq_enable, 3'h0};
      IDX_PIR: regRead = peripheral_irq_flags;
      IDX_PIE: regRead = peripheral_irq_enables;
      IDX_T1_COUNT: regRead = cnt1;
      IDX_T2_COUNT: regRead = cnt2;
      IDX_T1_PERIOD: regRead = per1;
      IDX_T2_PERIOD: regRead = per2;
      IDX_T3_LO: regRead = cnt3[7:0];
      IDX_T3_HI: regRead = cnt3[15:8];
      IDX_P3_LO: regRead = per3[7:0];
      IDX_P3_HI: regRead = per3[15:8];
      IDX_C2_LO: regRead = capture_two_pin[7:0];
      IDX_C2_HI: regRead = capture_two_pin[15:8];
      IDX_TCFG: regRead = timerCfg;
      IDX_TRUN: regRead = {capOvf[1], capOvf[0], timerRun};
      default: regRead = 8'h00;
    endcase
  endfunction : regRead

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= '0;
    end else begin
      wb_ack_o <= busReq & ~wb_ack_o;
      if (busReq && !wb_ack_o) wb_dat_o <= {24'h000000, regRead(idx)};
    end
  end

  // ****************************************
  // Checks
  // ****************************************
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (!rst_n);

  logic anyWr;
  assign anyWr = busWr;

  a_t1_period_wrap: assert property (wrap1 && !anyWr |=> cnt1 == 8'h00 && peripheral_irq_flags[B_T1IF])
    else $error("timer one did not wrap at period");
  a_t1_run_hold: assert property (!timerRun[B_T1ON] && !anyWr |=> $stable(cnt1))
    else $error("stopped timer one changed");
  a_t2_int_step: assert property (!timerCfg[B_T2CS] && timerRun[B_T2ON] && instrTick
      && cnt2 != per2 && !anyWr |=> cnt2 == $past(cnt2) + 8'h01)
    else $error("timer two missed an instruction tick");
  a_t1_ext_edge: assert property (timerCfg[B_T1CS] && timerRun[B_T1ON] && !pinFall[PIN_SHARED_TIMER_CLOCK_PIN]
      && !anyWr |=> $stable(cnt1))
    else $error("external timer moved without a pin edge");
  a_irq_gating: assert property (periphIrq |-> $past(peripheral_irq_enable) && !$past(global_irq_disable) && $past(pendAny))
    else $error("interrupt raised while gated");
  a_t3_period: assert property (tick3 && !dualCap && cnt3 == per3 && !anyWr
      |=> cnt3 == 16'h0000 && peripheral_irq_flags[B_T3IF])
    else $error("wide timer missed its period");
  a_capture_one_pin_off: assert property ($rose(peripheral_irq_flags[B_CAPTURE_ONE_IRQ_FLAG]) |-> $past(dualCap) || $past(anyWr))
    else $error("capture one flagged in period mode");
  a_capture_two_pin_take: assert property (capTake[1] |=> capture_two_pin == $past(cnt3) && peripheral_irq_flags[B_CAPTURE_TWO_IRQ_FLAG])
    else $error("capture two lost its value");
  a_cap_protect: assert property (capLost[1] |=> $stable(capture_two_pin) && ovfMaster[1])
    else $error("unread capture overwritten");
  a_pre_count: assert property (pinRise[PIN_CAPTURE_TWO_PIN] |=> pre[1] == $past(pre[1]) + 4'h1)
    else $error("capture prescaler missed an edge");

  c_t1_wrap: cover property (wrap1);
  c_capture_two_pin_lost: cover property (capLost[1]);
  c_dual_capture: cover property (capTake[0]);
  c_irq_raised: cover property ($rose(periphIrq));
endmodule : tpc_timer_unit
`default_nettype wire

// ### tb/tpc_pin_model.sv
`default_nettype none
module tpc_pin_model
  import tpc_pkg::*;
(
  // Clock
  input wire logic ref_clk,
  // Pins toward the timer unit
  output logic [PIN_N-1:0] pins
);
  timeunit 1ns;
  timeprecision 1ps;
  // ****************************************
  // Idle levels: clocks high, captures low
  // ****************************************
  initial pins = 4'h3;
  // ****************************************
  // One full pulse, each level held 8 cycles
  // ****************************************
  task automatic pulse(input int idx);
    @(posedge ref_clk);
    pins[idx] <= ~pins[idx];
    repeat (8) @(posedge ref_clk);
    pins[idx] <= ~pins[idx];
    repeat (8) @(posedge ref_clk);
  endtask : pulse
endmodule : tpc_pin_model
`default_nettype wire

// ### tb/timer_period_capture_unit_tb.sv
`default_nettype none
module timer_period_capture_unit_tb
  import tpc_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic refClk = 1'b0;
  logic rstN = 1'b0;
  logic wbCyc = 1'b0;
  logic wbStb = 1'b0;
  logic wbWe = 1'b0;
  logic [31:0] wbAdr = 32'h0;
  logic [3:0] wbSel = 4'hF;
  logic [WB_DW-1:0] wbDatI = 32'h0;
  logic [WB_DW-1:0] wbDatO;
  logic wbAck;
  logic periphIrq;
  logic [PIN_N-1:0] pins;
  logic [7:0] rd;
  logic [7:0] a;
  int badCount = 0;
  int samplesChecked = 0;
  int cycles = 0;
  tpc_timer_unit i_tpc_timer_unit (
    .ref_clk(refClk), .rst_n(rstN), .wb_cyc_i(wbCyc), .wb_stb_i(wbStb), .wb_we_i(wbWe),
    .wb_adr_i(wbAdr), .wb_sel_i(wbSel), .wb_dat_i(wbDatI), .wb_dat_o(wbDatO),
    .wb_ack_o(wbAck), .sharedTimerClockPin(pins[PIN_SHARED_TIMER_CLOCK_PIN]),
    .thirdTimerClockPin(pins[PIN_THIRD_TIMER_CLOCK_PIN]), .captureOnePin(pins[PIN_CAPTURE_ONE_PIN]),
    .captureTwoPin(pins[PIN_CAPTURE_TWO_PIN]), .periphIrq(periphIrq)
  );
  tpc_pin_model i_tpc_pin_model (.ref_clk(refClk), .pins(pins));
  initial begin
    forever #2 refClk = ~refClk;
  end
  // ****************************************
  // Checking and closing
  // ****************************************
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    samplesChecked++;
    if (got !== exp) begin
      badCount++;
      $display("ERROR %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic endSim();
    $display("mismatches %0d comparisons %0d", badCount, samplesChecked);
    if (badCount == 0 && samplesChecked > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : endSim
  always @(posedge refClk) begin
    cycles++;
    if (cycles == 60000) begin
      badCount++;
      $display("ERROR %0t run limit reached", $time);
      endSim();
    end
  end
  // ****************************************
  // Wishbone classic master
  // ****************************************
  task automatic wbXfer(input logic we, input logic [7:0] idx, input logic [7:0] wd);
    int n;
    n = 0;
    @(posedge refClk);
    wbCyc <= 1'b1;
    wbStb <= 1'b1;
    wbWe <= we;
    wbAdr <= {22'h0, idx, 2'h0};
    wbDatI <= {24'h0, wd};
    do begin
      @(posedge refClk);
      n++;
    end while (wbAck !== 1'b1 && n < 50);
    if (n >= 50) begin
      badCount++;
      $display("ERROR %0t no bus answer", $time);
    end
    rd = wbDatO[7:0];
    wbCyc <= 1'b0;
    wbStb <= 1'b0;
  endtask : wbXfer
  task automatic wr(input logic [7:0] idx, input logic [7:0] d);
    wbXfer(1'b1, idx, d);
  endtask : wr
  task automatic rdReg(input logic [7:0] idx);
    wbXfer(1'b0, idx, 8'h00);
  endtask : rdReg
  task automatic rdChk(input logic [7:0] idx, input logic [7:0] exp);
    rdReg(idx);
    chk({8'h00, rd}, {8'h00, exp});
  endtask : rdChk
  task automatic pollBit(input logic [7:0] idx, input int b);
    int k;
    k = 0;
    do begin
      rdReg(idx);
      k++;
    end while (rd[b] !== 1'b1 && k < 200);
    chk({15'h0, rd[b]}, 16'h0001);
  endtask : pollBit
  task automatic capStep(input int n);
    int k;
    k = 0;
    do begin
      i_tpc_pin_model.pulse(PIN_CAPTURE_TWO_PIN);
      rdReg(IDX_PIR);
      k++;
    end while (rd[B_CAPTURE_TWO_IRQ_FLAG] !== 1'b1 && k < 17);
    rdReg(IDX_C2_LO);
    rdReg(IDX_C2_HI);
    wr(IDX_PIR, 8'h00);
    repeat (n - 1) i_tpc_pin_model.pulse(PIN_CAPTURE_TWO_PIN);
    rdReg(IDX_PIR);
    chk({15'h0, rd[B_CAPTURE_TWO_IRQ_FLAG]}, 16'h0000);
    i_tpc_pin_model.pulse(PIN_CAPTURE_TWO_PIN);
    rdReg(IDX_PIR);
    chk({15'h0, rd[B_CAPTURE_TWO_IRQ_FLAG]}, 16'h0001);
    rdChk(IDX_C2_LO, 8'h37);
    rdChk(IDX_C2_HI, 8'h12);
    wr(IDX_PIR, 8'h00);
  endtask : capStep
  // ****************************************
  // Main sequence
  // ****************************************
  initial begin
    repeat (8) @(posedge refClk);
    rstN <= 1'b1;
    rdChk(IDX_PIR, RST_PIR);
    rdChk(IDX_TCFG, 8'h00);
    rdChk(IDX_TRUN, 8'h00);
    rdChk(IDX_CPU_STATUS, 8'h3C);
    rdChk(IDX_T1_PERIOD, 8'hFF);
    rdChk(IDX_P3_HI, 8'hFF);
    rdChk(8'h01, 8'h00);
    wr(IDX_TRUN, 8'h01);
    rdReg(IDX_T1_COUNT);
    a = rd;
    repeat (40) @(posedge refClk);
    rdReg(IDX_T1_COUNT);
    chk({15'h0, 8'(rd - a) inside {8'd10, 8'd11}}, 16'h0001);
    wr(IDX_TRUN, 8'h00);
    rdReg(IDX_T1_COUNT);
    a = rd;
    repeat (20) @(posedge refClk);
    rdChk(IDX_T1_COUNT, a);
    wr(IDX_T1_COUNT, 8'h00);
    wr(IDX_T1_PERIOD, 8'h03);
    wr(IDX_PIR, 8'h00);
    wr(IDX_TRUN, 8'h01);
    repeat (4) begin
      rdReg(IDX_T1_COUNT);
      chk({15'h0, rd <= 8'h03}, 16'h0001);
    end
    pollBit(IDX_PIR, B_T1IF);
    wr(IDX_TRUN, 8'h00);
    rdReg(IDX_PIR);
    chk({15'h0, rd[B_T2IF]}, 16'h0000);
    rdReg(IDX_T1_COUNT);
    a = rd;
    rdChk(IDX_T2_COUNT, 8'h00);
    wr(IDX_PIE, 8'h10);
    wr(IDX_CORE_INT, 8'h08);
    repeat (3) @(posedge refClk);
    chk({15'h0, periphIrq}, 16'h0000);
    wr(IDX_CPU_STATUS, 8'h00);
    repeat (3) @(posedge refClk);
    chk({15'h0, periphIrq}, 16'h0001);
    rdChk(IDX_CORE_INT, 8'h88);
    wr(IDX_PIR, 8'h00);
    repeat (3) @(posedge refClk);
    chk({15'h0, periphIrq}, 16'h0000);
    wr(IDX_TCFG, 8'h03);
    wr(IDX_TRUN, 8'h03);
    repeat (5) i_tpc_pin_model.pulse(PIN_SHARED_TIMER_CLOCK_PIN);
    rdChk(IDX_T2_COUNT, 8'h05);
    rdChk(IDX_T1_COUNT, (a + 8'h05) & 8'h03);
    wr(IDX_TRUN, 8'h00);
    wr(IDX_P3_LO, 8'h05);
    wr(IDX_P3_HI, 8'h00);
    wr(IDX_TCFG, 8'h10);
    wr(IDX_TRUN, 8'h04);
    pollBit(IDX_PIR, B_T3IF);
    repeat (3) begin
      rdReg(IDX_T3_LO);
      chk({15'h0, rd <= 8'h05}, 16'h0001);
    end
    i_tpc_pin_model.pulse(PIN_CAPTURE_ONE_PIN);
    rdReg(IDX_PIR);
    chk({15'h0, rd[B_CAPTURE_ONE_IRQ_FLAG]}, 16'h0000);
    wr(IDX_TRUN, 8'h00);
    wr(IDX_PIR, 8'h00);
    rdReg(IDX_T3_LO);
    a = rd;
    repeat (40) @(posedge refClk);
    rdChk(IDX_T3_LO, a);
    rdReg(IDX_PIR);
    chk({15'h0, rd[B_T3IF]}, 16'h0000);
    wr(IDX_P3_LO, 8'hFF);
    wr(IDX_P3_HI, 8'hFF);
    wr(IDX_T3_LO, 8'h34);
    wr(IDX_T3_HI, 8'h12);
    rdChk(IDX_T3_LO, 8'h34);
    rdChk(IDX_T3_HI, 8'h12);
    wr(IDX_TCFG, 8'h04);
    wr(IDX_TRUN, 8'h04);
    repeat (3) i_tpc_pin_model.pulse(PIN_THIRD_TIMER_CLOCK_PIN);
    wr(IDX_TRUN, 8'h00);
    rdChk(IDX_T3_LO, 8'h37);
    for (int c = 0; c < 4; c++) begin
      wr(IDX_TCFG, 8'(c << B_C2ED));
      capStep((c == 3) ? 16 : ((c == 2) ? 4 : 1));
    end
    wr(IDX_TCFG, 8'h40);
    i_tpc_pin_model.pulse(PIN_CAPTURE_TWO_PIN);
    wr(IDX_T3_LO, 8'h78);
    i_tpc_pin_model.pulse(PIN_CAPTURE_TWO_PIN);
    rdChk(IDX_C2_LO, 8'h37);
    rdChk(IDX_C2_HI, 8'h12);
    rdReg(IDX_TRUN);
    chk({15'h0, rd[B_C2OVF]}, 16'h0001);
    wr(IDX_PIR, 8'h00);
    wr(IDX_TRUN, 8'h08);
    wr(IDX_TCFG, 8'h10);
    i_tpc_pin_model.pulse(PIN_CAPTURE_ONE_PIN);
    rdChk(IDX_P3_LO, 8'h78);
    rdChk(IDX_P3_HI, 8'h12);
    rdReg(IDX_PIR);
    chk({15'h0, rd[B_CAPTURE_ONE_IRQ_FLAG]}, 16'h0001);
    wr(IDX_T3_LO, 8'hF0);
    wr(IDX_T3_HI, 8'hFF);
    wr(IDX_PIR, 8'h00);
    wr(IDX_TCFG, 8'h00);
    wr(IDX_TRUN, 8'h0C);
    pollBit(IDX_PIR, B_T3IF);
    rdChk(IDX_T3_HI, 8'h00);
    endSim();
  end
endmodule : timer_period_capture_unit_tb
`default_nettype wire
